// ===== rtl/rx_sample_vote.sv
`timescale 1ns/1ps
`default_nettype none

// majority of three samples, with disagreement marking noise
module rx_sample_vote (
   input  wire logic [2:0] samples_i,
   output logic            bit_o,
   output logic            noise_o
);

   always_comb begin
      bit_o   = (samples_i[0] & samples_i[1]) | (samples_i[0] & samples_i[2])
              | (samples_i[1] & samples_i[2]);
      noise_o = ~((samples_i == 3'h0) | (samples_i == 3'h7));
   end

endmodule

`default_nettype wire

// ===== rtl/rx_status_cfg.svh
`ifndef RX_STATUS_CFG_SVH
`define RX_STATUS_CFG_SVH

// ----------------------------------------------------------------
// register map (word index on the plain register port)
// ----------------------------------------------------------------
`define ADDR_STATUS_ONE   4'h0
`define ADDR_STATUS_TWO   4'h1
`define ADDR_DATA         4'h2
`define ADDR_CONTROL      4'h3
`define ADDR_DIVISOR      4'h4
`define ADDR_IRQ_STATUS   4'h5
`define ADDR_IRQ_MASK     4'h6
`define ADDR_W            4

// ----------------------------------------------------------------
// status one bit positions
// ----------------------------------------------------------------
`define S1_RX_FULL_FLAG           5
`define S1_IDLE           4
`define S1_OVR            3
`define S1_NOISE          2
`define S1_FRAME          1
`define S1_PARITY         0

// ----------------------------------------------------------------
// status two / control bit positions
// ----------------------------------------------------------------
`define S2_LONG_BREAK     2
`define S2_ACTIVE         0
`define CTL_ENABLE        0
`define CTL_NINE_BIT      1
`define CTL_PARITY_ON     2
`define CTL_PARITY_ODD    3
`define CTL_IDLE_MODE     4
`define CTL_LONG_BREAK    5

// ----------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------
`define CTL_RESET         8'h00
`define DIV_RESET         16'h001B
`define MASK_RESET        8'h00
`define BITS_CHAR_SHORT   5'h0A
`define BITS_CHAR_LONG    5'h0B
`define BREAK_SHORT       5'h0A
`define BREAK_SHORT_NINE  5'h0B
`define BREAK_LONG        5'h0D
`define BREAK_LONG_NINE   5'h0E
`define OVERSAMPLE        5'h10

`endif

// ===== rtl/rx_status_pkg.sv
package rx_status_pkg;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } reg_req_t;

   typedef struct packed {
      logic       valid;
      logic [8:0] data;
      logic       noise;
      logic       frame_err;
      logic       parity_err;
      logic       is_break;
   } rx_char_t;

   typedef enum logic [2:0] {
      RX_IDLE,
      RX_START,
      RX_DATA,
      RX_PARITY,
      RX_STOP
   } rx_state_t;

endpackage

// ===== rtl/uart_rx_status.sv
// Functional notes
// RQ1 - idle is raised after one full character time (10 or 11 bits) of high line following activity.
// RQ2 - with idle_count_mode 0 idle bit times are counted right after the start bit.
// RQ3 - with idle_count_mode 1 idle bit times are counted only after the stop bit.
// RQ4 - idle clears on a status one read showing it set followed by a data read.
// RQ5 - once cleared, idle stays clear until a new character sets rx_full_flag.
// RQ6 - a character arriving while the data register is unread sets overrun and is dropped.
// RQ7 - overrun clears on a status one read showing it set followed by a data read.
// RQ8 - seven start samples and three per data and stop bit; disagreement sets noise with rx_full.
// RQ9 - noise clears on a status one read followed by a data read.
// RQ10 - a low stop bit sets the framing error flag together with rx_full.
// RQ11 - framing error clears on a status one read showing it set followed by a data read.
// RQ12 - with parity checking on, a parity mismatch sets the parity flag with rx_full.
// RQ13 - parity error clears on a status one read followed by a data read.
// RQ14 - long_break_select picks a 10/11 or 13/14 bit break length; with 13/14 selected break_o is never raised.
// RQ15 - framing error detection ignores long_break_select.
// RQ16 - rx_active_flag sets at a valid start bit and clears when idle line is seen; the code also sets it at phase 7 of a rejected false start.
// RQ17 - rx_full_flag sets when a character moves into the data register.
`timescale 1ns/1ps
`default_nettype none
`include "rx_status_cfg.svh"

module uart_rx_status (
   input  wire logic                    clock_i,
   input  wire logic                    rstn_i,
   input  wire rx_status_pkg::reg_req_t req_i,
   input  wire logic                    rx_line_i,
   output logic [7:0]                   rdata_o,
   output logic                         irq_o,
   output logic                         rx_full_o,
   output logic                         break_o
);
   import rx_status_pkg::*;

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [7:0]  ctl_reg;
   logic [15:0] div_reg;
   logic [7:0]  mask_reg;
   logic [7:0]  irq_reg;
   logic [8:0]  data_reg;
   logic        rx_full_flag_reg;
   logic        idle_reg;
   logic        ovr_reg;
   logic        noise_reg;
   logic        frame_reg;
   logic        parity_reg;
   logic        active_reg;
   logic        idle_armed_reg;
   logic [7:0]  snap_reg;

   logic [15:0] tick_cnt_reg;
   logic [3:0]  sub_cnt_reg;
   logic [4:0]  idle_cnt_reg;
   logic [3:0]  bit_idx_reg;
   logic [2:0]  start_ones_reg;
   logic [2:0]  samp_reg;
   logic [8:0]  shift_reg;
   logic        noise_acc_reg;
   logic        par_bit_reg;
   logic        counting_reg;
   rx_state_t   state_reg;

   logic        nine;
   logic        tick;
   logic        bit_end;
   logic [4:0]  char_bits;
   logic [4:0]  break_len;
   logic [3:0]  data_bits;
   logic        voted;
   logic        vote_noise;
   logic        idle_event;
   logic        deliver;
   logic        frame_now;
   logic        parity_now;
   logic        data_rd;
   logic [7:0]  status_one;
   logic [7:0]  status_two;
   logic [7:0]  irq_events;
   logic [7:0]  status_one_q;

   rx_sample_vote u_vote (
      .samples_i (samp_reg),
      .bit_o     (voted),
      .noise_o   (vote_noise)
   );

   always_comb begin
      nine       = ctl_reg[`CTL_NINE_BIT];
      tick       = (tick_cnt_reg == 16'h0000);
      bit_end    = tick && (sub_cnt_reg == 4'(`OVERSAMPLE - 5'h01));
      char_bits  = nine ? `BITS_CHAR_LONG : `BITS_CHAR_SHORT;
      data_bits  = nine ? 4'h9 : 4'h8;
      // the parity bit replaces the top data bit when checking is on
      if (ctl_reg[`CTL_PARITY_ON]) begin
         data_bits = data_bits - 4'h1;
      end
      if (ctl_reg[`CTL_LONG_BREAK]) begin
         break_len = nine ? `BREAK_LONG_NINE : `BREAK_LONG;
      end else begin
         break_len = nine ? `BREAK_SHORT_NINE : `BREAK_SHORT;
      end
      data_rd    = req_i.rd && (req_i.addr == `ADDR_DATA);
      frame_now  = ~voted; // RQ15
      parity_now = ctl_reg[`CTL_PARITY_ON]
                   && ((^shift_reg ^ ctl_reg[`CTL_PARITY_ODD]) != par_bit_reg);
      deliver    = (state_reg == RX_STOP) && bit_end;
      idle_event = counting_reg && idle_armed_reg && tick
                   && (sub_cnt_reg == 4'(`OVERSAMPLE - 5'h01))
                   && rx_line_i && (idle_cnt_reg == char_bits - 5'h01);
      status_one = 8'h00;
      status_one[`S1_RX_FULL_FLAG]   = rx_full_flag_reg;
      status_one[`S1_IDLE]   = idle_reg;
      status_one[`S1_OVR]    = ovr_reg;
      status_one[`S1_NOISE]  = noise_reg;
      status_one[`S1_FRAME]  = frame_reg;
      status_one[`S1_PARITY] = parity_reg;
      status_two = 8'h00;
      status_two[`S2_LONG_BREAK] = ctl_reg[`CTL_LONG_BREAK];
      status_two[`S2_ACTIVE]     = active_reg;
      irq_events = status_one;
   end

   // ----------------------------------------------------------------
   // software registers
   // ----------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         ctl_reg  <= `CTL_RESET;
         div_reg  <= `DIV_RESET;
         mask_reg <= `MASK_RESET;
      end else if (req_i.wr) begin
         case (req_i.addr)
            `ADDR_CONTROL:  ctl_reg  <= req_i.wdata;
            `ADDR_DIVISOR:  div_reg  <= {8'h00, req_i.wdata};
            `ADDR_IRQ_MASK: mask_reg <= req_i.wdata;
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // oversample timing
   // ----------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (!rstn_i || !ctl_reg[`CTL_ENABLE]) begin
         tick_cnt_reg <= 16'h0000;
      end else if (tick) begin
         tick_cnt_reg <= div_reg;
      end else begin
         tick_cnt_reg <= tick_cnt_reg - 16'h0001;
      end
   end

   // ----------------------------------------------------------------
   // receive shifter
   // ----------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (!rstn_i || !ctl_reg[`CTL_ENABLE]) begin
         state_reg      <= RX_IDLE;
         sub_cnt_reg    <= 4'h0;
         bit_idx_reg    <= 4'h0;
         start_ones_reg <= 3'h0;
         samp_reg       <= 3'h0;
         shift_reg      <= 9'h000;
         noise_acc_reg  <= 1'b0;
         par_bit_reg    <= 1'b0;
      end else if (tick) begin
         sub_cnt_reg <= sub_cnt_reg + 4'h1;
         // samples 7,8,9 of 16 vote for data and stop bits
         if (sub_cnt_reg == 4'h7 || sub_cnt_reg == 4'h8 || sub_cnt_reg == 4'h9) begin
            samp_reg <= {samp_reg[1:0], rx_line_i};
         end
         case (state_reg)
            RX_IDLE: begin
               // phase runs free while idle so idle bit times still end
               if (!rx_line_i) begin
                  sub_cnt_reg    <= 4'h1;
                  state_reg      <= RX_START;
                  start_ones_reg <= 3'h0;
                  noise_acc_reg  <= 1'b0;
               end
            end
            RX_START: begin
               // seven samples in the start bit, at phases 1..7
               if (sub_cnt_reg <= 4'h7 && rx_line_i) begin
                  start_ones_reg <= start_ones_reg + 3'h1;
               end
               if (sub_cnt_reg == 4'h7) begin
                  if (start_ones_reg >= 3'h3 && rx_line_i) begin
                     state_reg <= RX_IDLE; // false start rejected
                  end else if (start_ones_reg != 3'h0 || rx_line_i) begin
                     noise_acc_reg <= 1'b1; // RQ8
                  end
               end
               if (bit_end) begin
                  state_reg   <= RX_DATA;
                  bit_idx_reg <= 4'h0;
                  shift_reg   <= 9'h000;
               end
            end
            RX_DATA: begin
               if (bit_end) begin
                  shift_reg[bit_idx_reg] <= voted;
                  noise_acc_reg <= noise_acc_reg | vote_noise; // RQ8
                  bit_idx_reg   <= bit_idx_reg + 4'h1;
                  if (bit_idx_reg == data_bits - 4'h1) begin
                     state_reg <= ctl_reg[`CTL_PARITY_ON] ? RX_PARITY : RX_STOP;
                  end
               end
            end
            RX_PARITY: begin
               if (bit_end) begin
                  par_bit_reg   <= voted;
                  noise_acc_reg <= noise_acc_reg | vote_noise; // RQ8
                  state_reg     <= RX_STOP;
               end
            end
            RX_STOP: begin
               if (bit_end) begin
                  state_reg <= RX_IDLE;
               end
            end
            default: state_reg <= RX_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // idle line counting
   // ----------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (!rstn_i || !ctl_reg[`CTL_ENABLE]) begin
         idle_cnt_reg <= 5'h00;
         counting_reg <= 1'b0;
      end else if (state_reg == RX_START || (!rx_line_i && tick)) begin
         // any low resets the run; mode 0 counts from after the start bit
         idle_cnt_reg <= 5'h00;
         counting_reg <= (state_reg != RX_IDLE)
                         && !ctl_reg[`CTL_IDLE_MODE]; // RQ2
      end else if (deliver) begin
         // mode 0 lets a high stop bit count toward idle
         idle_cnt_reg <= ctl_reg[`CTL_IDLE_MODE] ? 5'h00
                         : idle_cnt_reg + {4'h0, rx_line_i}; // RQ2
         counting_reg <= 1'b1; // RQ3
      end else if (bit_end && counting_reg && rx_line_i
                   && idle_cnt_reg != char_bits) begin
         idle_cnt_reg <= idle_cnt_reg + 5'h01; // RQ1
      end
   end

   // ----------------------------------------------------------------
   // status flags and clearing sequence
   // ----------------------------------------------------------------
   // the status snapshot remembers which flags a status one read saw set
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         snap_reg <= 8'h00;
      end else if (req_i.rd && req_i.addr == `ADDR_STATUS_ONE) begin
         snap_reg <= status_one;
      end else if (data_rd) begin
         snap_reg <= 8'h00;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         rx_full_flag_reg   <= 1'b0;
         ovr_reg    <= 1'b0;
         noise_reg  <= 1'b0;
         frame_reg  <= 1'b0;
         parity_reg <= 1'b0;
         data_reg   <= 9'h000;
         break_o    <= 1'b0;
      end else begin
         if (data_rd) begin
            rx_full_flag_reg   <= rx_full_flag_reg   & ~snap_reg[`S1_RX_FULL_FLAG];
            ovr_reg    <= ovr_reg    & ~snap_reg[`S1_OVR];    // RQ7
            noise_reg  <= noise_reg  & ~snap_reg[`S1_NOISE];  // RQ9
            frame_reg  <= frame_reg  & ~snap_reg[`S1_FRAME];  // RQ11
            parity_reg <= parity_reg & ~snap_reg[`S1_PARITY]; // RQ13
         end
         if (deliver) begin
            if (rx_full_flag_reg && !(data_rd && snap_reg[`S1_RX_FULL_FLAG])) begin
               ovr_reg <= 1'b1; // RQ6
            end else begin
               rx_full_flag_reg   <= 1'b1;                         // RQ17
               data_reg   <= shift_reg;
               noise_reg  <= noise_acc_reg | vote_noise;   // RQ8
               frame_reg  <= frame_now;                    // RQ10
               parity_reg <= parity_now;                   // RQ12
               // break: every frame bit read low, only when the chosen length fits in the frame
               break_o    <= frame_now && (shift_reg == 9'h000)
                             && !par_bit_reg
                             && (break_len <= char_bits); // RQ14
            end
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         idle_reg       <= 1'b0;
         idle_armed_reg <= 1'b0;
         active_reg     <= 1'b0;
      end else begin
         if (data_rd && snap_reg[`S1_IDLE]) begin
            idle_reg <= 1'b0; // RQ4
         end
         if (deliver) begin
            idle_armed_reg <= 1'b1; // RQ5
         end else if (idle_event) begin
            idle_armed_reg <= 1'b0; // RQ5
         end
         if (idle_event) begin
            idle_reg <= 1'b1; // RQ1
         end
         if (state_reg == RX_START && tick && sub_cnt_reg == 4'h7) begin
            active_reg <= 1'b1; // RQ16
         end else if (idle_event || (counting_reg && rx_line_i
                      && idle_cnt_reg == char_bits)) begin
            active_reg <= 1'b0; // RQ16
         end
      end
   end

   // ----------------------------------------------------------------
   // interrupt status, mask, read port
   // ----------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         irq_reg <= 8'h00;
      end else if (req_i.wr && req_i.addr == `ADDR_IRQ_STATUS) begin
         // a rising event in the clearing cycle wins over the clear
         irq_reg <= (irq_reg & ~req_i.wdata) | (irq_events & ~status_one_q);
      end else begin
         irq_reg <= irq_reg | (irq_events & ~status_one_q);
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         status_one_q <= 8'h00;
         irq_o        <= 1'b0;
         rx_full_o    <= 1'b0;
      end else begin
         status_one_q <= status_one;
         irq_o        <= |(irq_reg & mask_reg);
         rx_full_o    <= rx_full_flag_reg;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         rdata_o <= 8'h00;
      end else if (req_i.rd) begin
         case (req_i.addr)
            `ADDR_STATUS_ONE: rdata_o <= status_one;
            `ADDR_STATUS_TWO: rdata_o <= status_two;
            `ADDR_DATA:       rdata_o <= data_reg[7:0];
            `ADDR_CONTROL:    rdata_o <= ctl_reg;
            `ADDR_DIVISOR:    rdata_o <= div_reg[7:0];
            `ADDR_IRQ_STATUS: rdata_o <= irq_reg;
            `ADDR_IRQ_MASK:   rdata_o <= mask_reg;
            default:          rdata_o <= 8'h00;
         endcase
      end else begin
         rdata_o <= 8'h00;
      end
   end

endmodule

`default_nettype wire

// ===== verif/uart_rx_status_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "rx_status_cfg.svh"

module uart_rx_status_checker (
   input wire logic                    clock_i,
   input wire logic                    rstn_i,
   input wire rx_status_pkg::reg_req_t req_i,
   input wire logic                    rx_line_i,
   input wire logic [7:0]              rdata_o,
   input wire logic                    irq_o,
   input wire logic                    rx_full_o,
   input wire logic                    break_o
);
   import rx_status_pkg::*;

   // ----------------------------------------------------------------
   // shadows of what software wrote and read
   // ----------------------------------------------------------------
   logic [7:0] mask_reg;
   logic [2:0] dread_reg;

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         mask_reg <= `MASK_RESET;
      end else if (req_i.wr && req_i.addr == `ADDR_IRQ_MASK) begin
         mask_reg <= req_i.wdata;
      end
   end

   // three cycles cover the lag of the flag and of its output copy
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         dread_reg <= 3'h0;
      end else begin
         dread_reg <= {dread_reg[1:0], req_i.rd && req_i.addr == `ADDR_DATA};
      end
   end

   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rstn_i);

   sequence status_rd;
      req_i.rd && req_i.addr == `ADDR_STATUS_ONE;
   endsequence

   sequence data_rd_full;
      req_i.rd && req_i.addr == `ADDR_DATA && rdata_o[`S1_RX_FULL_FLAG];
   endsequence

   AST_RDATA_QUIET: assert property (!$past(req_i.rd) |-> rdata_o == 8'h00)
      else $error("read data not zero outside a read");
   AST_UNMAPPED: assert property (req_i.rd && req_i.addr > 4'h6
      |=> rdata_o == 8'h00) else $error("unmapped read not zero");
   AST_FULL_MATCH: assert property (status_rd |=>
      rdata_o[`S1_RX_FULL_FLAG] == rx_full_o) else $error("status and full differ");
   AST_FULL_CLEAR: assert property (status_rd ##1 data_rd_full
      |-> ##[1:3] !rx_full_o) else $error("full not cleared by sequence");
   AST_FULL_HOLD: assert property ($fell(rx_full_o) |-> dread_reg != 3'h0)
      else $error("full dropped without a data read");
   AST_IRQ_CAUSE: assert property ($rose(irq_o) |-> $past(mask_reg) != 8'h00)
      else $error("interrupt raised with mask clear");
   AST_IRQ_MASKED: assert property ((mask_reg == 8'h00) [*2] |-> !irq_o)
      else $error("interrupt high while masked");
   AST_BREAK_FULL: assert property ($rose(break_o) |-> ##[0:2] rx_full_o)
      else $error("break without delivered character");
endmodule

bind uart_rx_status uart_rx_status_checker checker_i (
   .clock_i   (clock_i),
   .rstn_i    (rstn_i),
   .req_i     (req_i),
   .rx_line_i (rx_line_i),
   .rdata_o   (rdata_o),
   .irq_o     (irq_o),
   .rx_full_o (rx_full_o),
   .break_o   (break_o)
);
`default_nettype wire

// ===== verif/uart_rx_status_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "rx_status_cfg.svh"

module uart_rx_status_tb;
   import rx_status_pkg::*;

   localparam int BIT_CLKS = 32;
   localparam logic [7:0] T_DAT [5] = '{8'h5A, 8'h3C, 8'h01, 8'h03, 8'h00};
   localparam logic [7:0] T_CTL [5] = '{8'h01, 8'h01, 8'h05, 8'h05, 8'h21};
   localparam logic [7:0] T_ST  [5] = '{8'h24, 8'h22, 8'h21, 8'h20, 8'h22};
   localparam logic       T_STP [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
   localparam logic       T_GLT [5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};

   logic       clock_i;
   logic       rstn_i;
   reg_req_t   req;
   logic       line;
   logic [7:0] rdata;
   logic       irq;
   logic       full;
   logic       brk;
   logic [7:0] v;
   int         error_cnt;
   int         compares;

   uart_rx_status uart_rx_status_i (
      .clock_i   (clock_i),
      .rstn_i    (rstn_i),
      .req_i     (req),
      .rx_line_i (line),
      .rdata_o   (rdata),
      .irq_o     (irq),
      .rx_full_o (full),
      .break_o   (brk)
   );

   uart_tx_model #(.BIT_CLKS(BIT_CLKS)) uart_tx_model_i (
      .clock_i (clock_i),
      .line_o  (line)
   );

   initial begin
      clock_i = 1'b0;
      forever #10 clock_i = ~clock_i;
   end

   // ----------------------------------------------------------------
   // bus and check tasks, all entered just after a rising edge
   // ----------------------------------------------------------------
   task automatic check(input string nm, input logic [7:0] s, e);
      compares++;
      if (s !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      req.addr <= a;
      req.wdata <= d;
      req.wr <= 1'b1;
      @(posedge clock_i);
      req.wr <= 1'b0;
      // one edge apart so a following write never reassigns the strobe
      @(posedge clock_i);
   endtask

   // data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      req.addr <= a;
      req.rd <= 1'b1;
      @(posedge clock_i);
      req.rd <= 1'b0;
      @(posedge clock_i);
      d = rdata;
   endtask

   task automatic wait_full();
      for (int n = 0; n < 8 * BIT_CLKS && full !== 1'b1; n++) begin
         @(posedge clock_i);
      end
      check("rx_full", {7'h00, full}, 8'h01);
   endtask

   // idle bit masked: its moment depends on the line, not on the char
   task automatic rx_check(input string nm, input logic [7:0] st, d);
      rd(`ADDR_STATUS_ONE, v);
      check(nm, v & 8'hEF, st);
      rd(`ADDR_DATA, v);
      check(nm, v, d);
   endtask

   task automatic stop_test();
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      #2000000;
      error_cnt++;
      stop_test();
   end

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      error_cnt = 0;
      compares = 0;
      rstn_i = 1'b0;
      req = '0;
      repeat (4) @(posedge clock_i);
      rstn_i <= 1'b1;
      @(posedge clock_i);
      rd(`ADDR_CONTROL, v);
      check("control", v, `CTL_RESET);
      rd(`ADDR_DIVISOR, v);
      check("divisor", v, 8'h1B);
      rd(`ADDR_IRQ_MASK, v);
      check("mask", v, `MASK_RESET);
      rd(4'h7, v);
      check("unmapped", v, 8'h00);
      wr(`ADDR_STATUS_ONE, 8'hFF);
      rd(`ADDR_STATUS_ONE, v);
      check("status one", v, 8'h00);
      $display("test reset done");
      wr(`ADDR_DIVISOR, 8'h01);
      for (int m = 0; m < 2; m++) begin
         wr(`ADDR_CONTROL, m ? 8'h11 : 8'h01);
         fork
            uart_tx_model_i.send(8'hFF, 1'b1, 1'b0);
            begin
               repeat (5 * BIT_CLKS) @(posedge clock_i);
               rd(`ADDR_STATUS_TWO, v);
               check("active", v & 8'h01, 8'h01);
            end
         join
         wait_full();
         repeat (4 * BIT_CLKS) @(posedge clock_i);
         rd(`ADDR_STATUS_ONE, v);
         check("idle early", v & 8'h10, m ? 8'h00 : 8'h10);
         repeat (8 * BIT_CLKS) @(posedge clock_i);
         rd(`ADDR_STATUS_ONE, v);
         check("idle", v, 8'h30);
         rd(`ADDR_DATA, v);
         check("data", v, 8'hFF);
         rd(`ADDR_STATUS_ONE, v);
         check("idle clear", v, 8'h00);
         rd(`ADDR_STATUS_TWO, v);
         check("active clear", v & 8'h01, 8'h00);
         repeat (12 * BIT_CLKS) @(posedge clock_i);
         rd(`ADDR_STATUS_ONE, v);
         check("idle once", v, 8'h00);
      end
      $display("test idle done");
      for (int k = 0; k < 5; k++) begin
         wr(`ADDR_CONTROL, T_CTL[k]);
         uart_tx_model_i.send(T_DAT[k], T_STP[k], T_GLT[k]);
         wait_full();
         rx_check("error flags", T_ST[k], T_DAT[k]);
         rd(`ADDR_STATUS_ONE, v);
         check("error clear", v & 8'hEF, 8'h00);
      end
      // a ten-bit low frame is shorter than the long break length
      check("break", {7'h00, brk}, 8'h00);
      rd(`ADDR_STATUS_TWO, v);
      check("long break", v & 8'h04, 8'h04);
      $display("test errors done");
      wr(`ADDR_CONTROL, 8'h01);
      uart_tx_model_i.send(8'h11, 1'b1, 1'b0);
      wait_full();
      uart_tx_model_i.send(8'h3C, 1'b0, 1'b0);
      repeat (2 * BIT_CLKS) @(posedge clock_i);
      rx_check("overrun", 8'h28, 8'h11);
      rd(`ADDR_STATUS_ONE, v);
      check("overrun clear", v & 8'hEF, 8'h00);
      $display("test overrun done");
      wr(`ADDR_IRQ_STATUS, 8'hFF);
      wr(`ADDR_IRQ_MASK, 8'h02);
      uart_tx_model_i.send(8'h3C, 1'b0, 1'b0);
      wait_full();
      repeat (3) @(posedge clock_i);
      check("irq set", {7'h00, irq}, 8'h01);
      rd(`ADDR_IRQ_STATUS, v);
      check("irq status", v & 8'h2F, 8'h22);
      wr(`ADDR_IRQ_STATUS, 8'h02);
      repeat (2) @(posedge clock_i);
      check("irq clear", {7'h00, irq}, 8'h00);
      rx_check("irq flags", 8'h22, 8'h3C);
      $display("test irq done");
      stop_test();
   end
endmodule
`default_nettype wire

// ===== verif/uart_tx_model.sv
`timescale 1ns/1ps
`default_nettype none

// remote transmitter: start, eight bits lsb first, stop, then idle high
module uart_tx_model #(
   parameter int BIT_CLKS = 32
) (
   input  wire logic clock_i,
   output logic      line_o
);
   initial line_o = 1'b1;

   task automatic hold(input logic v, input int n);
      line_o <= v;
      repeat (n) @(posedge clock_i);
   endtask

   // glitch: a two-clock flip mid first data bit, only when asked
   task automatic send(input logic [7:0] d, input logic stop, input logic g);
      hold(1'b0, BIT_CLKS);
      for (int i = 0; i < 8; i++) begin
         if (g && i == 0) begin
            hold(d[i], 16);
            hold(~d[i], 2);
            hold(d[i], BIT_CLKS - 18);
         end else begin
            hold(d[i], BIT_CLKS);
         end
      end
      hold(stop, BIT_CLKS);
      line_o <= 1'b1;
   endtask
endmodule
`default_nettype wire
